// ---- pkg/afm_params.svh ----
// Constants of the rule action stage: register map, field positions, reset values, timing
`ifndef AFM_PARAMS_SVH
`define AFM_PARAMS_SVH

// Register byte addresses
`define AFM_ADDR_CONFIG      8'h00
`define AFM_ADDR_ACTION_HI   8'h04
`define AFM_ADDR_FWD_ACTION  8'h08
`define AFM_ADDR_STATUS      8'h0C
`define AFM_ADDR_MASK        8'h10
`define AFM_ADDR_COUNT       8'h14

// Decoded register indices
`define AFM_IDX_CONFIG       3'h0
`define AFM_IDX_ACTION_HI    3'h1
`define AFM_IDX_FWD_ACTION   3'h2
`define AFM_IDX_STATUS       3'h3
`define AFM_IDX_MASK         3'h4
`define AFM_IDX_COUNT        3'h5
`define AFM_IDX_NONE         3'h7

// Field positions
`define AFM_FWD_RP_LSB       7
`define AFM_FWD_MM_HI        6
`define AFM_FWD_MM_LO        5
`define AFM_FWD_UNIT_BIT     4
`define AFM_FWD_DIR_BIT      3
`define AFM_HI_PM_HI         7
`define AFM_HI_PM_LO         6
`define AFM_HI_P_HI          5
`define AFM_HI_P_LO          3
`define AFM_HI_RPE_BIT       2
`define AFM_HI_RP_HI         1
`define AFM_HI_RP_LO         0
`define AFM_CFG_KIND_HI      1
`define AFM_CFG_KIND_LO      0
`define AFM_CFG_EN_HI        3
`define AFM_CFG_EN_LO        2

// Encodings and reset values
`define AFM_MM_LUT_ONLY      2'b00
`define AFM_MM_OR            2'b01
`define AFM_MM_AND           2'b10
`define AFM_MM_RULE_ONLY     2'b11
`define AFM_KIND_COUNT       2'b01
`define AFM_EN_COUNT         2'b00
`define AFM_RST_BYTE         8'h00
`define AFM_RST_CFG          2'b00
`define AFM_RST_WORD         32'h0000_0000
`define AFM_RST_CNT          11'h000
`define AFM_RST_PORTS        5'h00

// Widths
`define AFM_PORTS            5
`define AFM_CNT_W            11
`define AFM_SUB_W            7
`define AFM_MS_W             10

// Timing: 100 MHz clock
`define AFM_CLK_PERIOD_NS    10
`define AFM_US_NS            1000
`define AFM_MS_US            1000
`define AFM_US_CYCLES        (`AFM_US_NS / `AFM_CLK_PERIOD_NS)

`endif

// ---- pkg/afm_pkg.sv ----
// Types of the rule action stage
`include "afm_params.svh"

package afm_pkg;

  typedef enum logic [2:0] {
    AFM_CNT_IDLE = 3'b001,
    AFM_CNT_RUN  = 3'b010,
    AFM_CNT_DONE = 3'b100
  } afm_cnt_state_type;

  typedef struct packed {
    logic [`AFM_SUB_W-1:0] sub;
    logic [`AFM_MS_W-1:0]  msc;
    logic                  tick;
  } afm_tick_state_type;

  typedef struct packed {
    logic                   hreadyout;
    logic                   hresp;
    logic [31:0]            hrdata;
    logic                   dph_wr;
    logic [2:0]             dph_idx;
    logic [1:0]             rule_kind_select;
    logic [1:0]             rule_action_enable;
    logic [7:0]             act_hi;
    logic [7:0]             act_fwd;
    logic                   status;
    logic                   mask;
    logic                   irq;
    logic                   reload;
    logic [`AFM_CNT_W-1:0]  cnt;
    afm_cnt_state_type      cst;
    logic                   fwd_valid;
    logic [`AFM_PORTS-1:0]  fwd_map;
    logic                   remark_en;
    logic [2:0]             remark_prio;
    logic [1:0]             prio_mode;
    logic [2:0]             prio_value;
  } afm_state_type;

endpackage : afm_pkg

// ---- test/afm_checker.sv ----
// Port-level assertions of the rule action stage
`timescale 1ns/100ps
`include "afm_params.svh"

module afm_checker
  import afm_pkg::*;
#(
  parameter int PORTS     = `AFM_PORTS,
  parameter int US_CYCLES = `AFM_US_CYCLES,
  parameter int MS_US     = `AFM_MS_US
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  input wire logic             pkt_match,
  input wire logic [PORTS-1:0] lut_map,
  input wire logic             fwd_valid,
  input wire logic [PORTS-1:0] fwd_map,
  input wire logic             remark_prio_enable,
  input wire logic [2:0]       remark_prio_value,
  input wire logic [1:0]       prio_select_mode,
  input wire logic [2:0]       prio_value,
  input wire logic             irq
);
  ////////////////////////////////////////////////////////////////
  // Shadow of the action bytes, rebuilt from observed bus writes
  logic             aph_wr;
  logic             rd_dph;
  logic [7:0]       aph_a;
  logic [7:0]       cfg_r;
  logic [7:0]       hi_r;
  logic [7:0]       fwd_r;
  logic             mask_r;
  logic             cntm;
  logic [2:0]       exp_rp;
  logic [PORTS-1:0] rmap;
  logic [PORTS-1:0] m_or;
  logic [PORTS-1:0] m_and;

  assign cntm   = cfg_r[1:0] == `AFM_KIND_COUNT && cfg_r[3:2] == `AFM_EN_COUNT;
  assign rmap   = fwd_r[PORTS-1:0];
  assign m_or   = lut_map | rmap;
  assign m_and  = lut_map & rmap;
  assign exp_rp = hi_r[2] ? {hi_r[1:0], fwd_r[7]} : 3'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aph_wr <= 1'h0;
      rd_dph <= 1'h0;
      aph_a  <= 8'h00;
      cfg_r  <= 8'h00;
      hi_r   <= 8'h00;
      fwd_r  <= 8'h00;
      mask_r <= 1'h0;
    end else if (hready) begin
      aph_wr <= hsel && htrans[1] && hwrite;
      rd_dph <= hsel && htrans[1] && !hwrite;
      aph_a  <= haddr[7:0];
      if (aph_wr && aph_a == `AFM_ADDR_CONFIG) cfg_r <= hwdata[7:0];
      if (aph_wr && aph_a == `AFM_ADDR_ACTION_HI) hi_r <= hwdata[7:0];
      if (aph_wr && aph_a == `AFM_ADDR_FWD_ACTION) fwd_r <= hwdata[7:0];
      if (aph_wr && aph_a == `AFM_ADDR_MASK) mask_r <= hwdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_pkt_plain;
    pkt_match && !cntm;
  endsequence
  sequence s_pkt_count;
    pkt_match && cntm;
  endsequence
  property p_comb(logic [1:0] m, logic [PORTS-1:0] e);
    s_pkt_plain ##0 fwd_r[6:5] == m |=> fwd_map == $past(e);
  endproperty

  a_mode_lut: assert property (p_comb(`AFM_MM_LUT_ONLY, lut_map))
    else $error("lut only map wrong");
  a_mode_or: assert property (p_comb(`AFM_MM_OR, m_or))
    else $error("or map wrong");
  a_mode_and: assert property (p_comb(`AFM_MM_AND, m_and))
    else $error("and map wrong");
  a_mode_rule: assert property (p_comb(`AFM_MM_RULE_ONLY, rmap))
    else $error("rule map wrong");
  a_remark_value: assert property (s_pkt_plain |=> remark_prio_value == $past(exp_rp))
    else $error("remark priority wrong");
  a_remark_enable: assert property (s_pkt_plain |=> remark_prio_enable == $past(hi_r[2]))
    else $error("remark enable wrong");
  a_prio_pass: assert property (s_pkt_plain |=>
    prio_select_mode == $past(hi_r[7:6]) && prio_value == $past(hi_r[5:3]))
    else $error("priority fields wrong");
  a_count_lut: assert property (s_pkt_count |=> fwd_map == $past(lut_map) && remark_prio_value == 3'h0 &&
    !remark_prio_enable && prio_select_mode == 2'h0 && prio_value == 3'h0)
    else $error("counter mode forwarding wrong");
  a_irq_masked: assert property (!mask_r |-> !irq)
    else $error("interrupt while masked");
  a_fwd_pulse: assert property (pkt_match |=> fwd_valid)
    else $error("forward pulse missing");
  a_fwd_quiet: assert property (!pkt_match |=> !fwd_valid && $stable(fwd_map))
    else $error("forward output moved without packet");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");
  a_rdata_idle: assert property (!rd_dph |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
endmodule : afm_checker

bind afm_top afm_checker #(.PORTS(PORTS), .US_CYCLES(US_CYCLES), .MS_US(MS_US)) u_afm_checker (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pkt_match(pkt_match), .lut_map(lut_map), .fwd_valid(fwd_valid), .fwd_map(fwd_map),
  .remark_prio_enable(remark_prio_enable), .remark_prio_value(remark_prio_value),
  .prio_select_mode(prio_select_mode), .prio_value(prio_value), .irq(irq)
);

// ---- test/test_acl_forward_map_action.sv ----
// Self-checking bench of the rule action stage
`timescale 1ns/100ps
`include "afm_params.svh"
`define CHK(g, e, m) begin comparisons++; \
  if ((g) !== (e)) begin fails++; $display("MISMATCH %0t %s", $time, m); end end

module test_acl_forward_map_action
  import afm_pkg::*;
;
  // Short tick counts keep the millisecond run brief
  localparam int UC = 4;
  localparam int MU = 4;

  logic        clk       = 1'h0;
  logic        rst       = 1'h1;
  logic        hsel      = 1'h0;
  logic [31:0] haddr     = 32'h0000_0000;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'h0;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic        pkt_match = 1'h0;
  logic [4:0]  lut_map   = 5'h00;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        fwd_valid;
  logic [4:0]  fwd_map;
  logic [2:0]  remark_prio_value;
  logic        irq;
  int          fails       = 0;
  int          comparisons = 0;

  always #5 clk = ~clk;
  assign hready = hreadyout;

  afm_top #(.PORTS(`AFM_PORTS), .US_CYCLES(UC), .MS_US(MU)) u_afm_top (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pkt_match(pkt_match), .lut_map(lut_map), .fwd_valid(fwd_valid),
    .fwd_map(fwd_map), .remark_prio_enable(), .remark_prio_value(remark_prio_value),
    .prio_select_mode(), .prio_value(), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////
  // Sampling mid-cycle avoids racing the slave's registered outputs
  task automatic wait_ready(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (hready !== 1'h1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    d = hrdata;
    @(posedge clk);
  endtask : wait_ready

  task automatic bus_write(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] d;
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= 1'h1;
    wait_ready(d);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, v};
    wait_ready(d);
  endtask : bus_write

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] d;
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= 1'h0;
    wait_ready(d);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    wait_ready(d);
    `CHK(d, e, m)
  endtask : expect_reg

  task automatic send_pkt(input logic [4:0] l, input logic [4:0] em, input logic [2:0] erp);
    pkt_match <= 1'h1;
    lut_map   <= l;
    @(posedge clk);
    pkt_match <= 1'h0;
    @(negedge clk);
    `CHK(fwd_valid, 1'h1, "forward pulse")
    `CHK(fwd_map, em, "forward map")
    `CHK(remark_prio_value, erp, "remark priority")
    @(posedge clk);
  endtask : send_pkt

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    expect_reg(`AFM_ADDR_FWD_ACTION, 32'h0, "action byte reset");
    expect_reg(`AFM_ADDR_CONFIG, 32'h0, "config reset");
    expect_reg(`AFM_ADDR_MASK, 32'h0, "mask reset");
    bus_write(8'h18, 8'hFF);
    expect_reg(8'h18, 32'h0, "unmapped read");
    `CHK(irq, 1'h0, "irq idle")
    $display("test reset done");
  endtask : t_reset

  task automatic t_modes();
    logic [4:0] em;
    bus_write(`AFM_ADDR_ACTION_HI, 8'h06);
    for (int m = 0; m < 4; m++) begin
      case (m)
        0: em = 5'h0E;
        1: em = 5'h0E | 5'h15;
        2: em = 5'h0E & 5'h15;
        default: em = 5'h15;
      endcase
      bus_write(`AFM_ADDR_FWD_ACTION, {1'h1, m[1:0], 5'h15});
      expect_reg(`AFM_ADDR_FWD_ACTION, {24'h0, 1'h1, m[1:0], 5'h15}, "action readback");
      send_pkt(5'h0E, em, 3'h5);
    end
    bus_write(`AFM_ADDR_ACTION_HI, 8'h02);
    send_pkt(5'h0E, 5'h15, 3'h0);
    $display("test modes done");
  endtask : t_modes

  task automatic t_count_up();
    bus_write(`AFM_ADDR_FWD_ACTION, 8'h68);
    bus_write(`AFM_ADDR_ACTION_HI, 8'h00);
    bus_write(`AFM_ADDR_CONFIG, 8'h01);
    repeat (4) @(posedge clk);
    send_pkt(5'h11, 5'h11, 3'h0);
    send_pkt(5'h11, 5'h11, 3'h0);
    expect_reg(`AFM_ADDR_COUNT, 32'h2, "count after two packets");
    send_pkt(5'h11, 5'h11, 3'h0);
    repeat (4) @(posedge clk);
    `CHK(irq, 1'h0, "masked event")
    expect_reg(`AFM_ADDR_COUNT, 32'h3, "count at target");
    bus_write(`AFM_ADDR_MASK, 8'h01);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'h1, "unmasked event")
    expect_reg(`AFM_ADDR_STATUS, 32'h1, "status set");
    repeat (2) @(posedge clk);
    `CHK(irq, 1'h0, "irq after clear")
    expect_reg(`AFM_ADDR_STATUS, 32'h0, "status cleared");
    $display("test count up done");
  endtask : t_count_up

  // Window allows one unit of tick phase each way plus load latency
  task automatic t_count_down(input logic [7:0] fa, input int t, input int u);
    int n;
    bus_write(`AFM_ADDR_FWD_ACTION, fa);
    n = 0;
    @(negedge clk);
    while (irq !== 1'h1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    `CHK(n >= (t - 1) * u && n <= (t + 1) * u + 8, 1'h1, "expiry time")
    expect_reg(`AFM_ADDR_STATUS, 32'h1, "expiry status");
    $display("test count down done");
  endtask : t_count_down

  // Leaving counter mode hands the map bits back to the combine logic
  task automatic t_leave();
    bus_write(`AFM_ADDR_STATUS, 8'h01);
    expect_reg(`AFM_ADDR_STATUS, 32'h0, "status write ignored");
    bus_write(`AFM_ADDR_CONFIG, 8'h05);
    expect_reg(`AFM_ADDR_CONFIG, 32'h5, "config readback");
    send_pkt(5'h11, 5'h10, 3'h0);
    $display("test leave counter done");
  endtask : t_leave

  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_modes();
    t_count_up();
    t_count_down(8'hA0, 5, UC);
    t_count_down(8'h50, 2, UC * MU);
    t_leave();
    final_report();
  end

  // Whole run needs well under a tenth of this span
  initial begin
    #(100_000);
    fails++;
    final_report();
  end
endmodule : test_acl_forward_map_action

// ---- verilog/afm_map_combine.sv ----
// Combines the rule port map with the look-up-table port map
`timescale 1ns/100ps
`include "afm_params.svh"

module afm_map_combine
  import afm_pkg::*;
#(
  parameter int PORTS = `AFM_PORTS
) (
  // Mode and maps
  input  wire logic [1:0]       map_combine_mode,
  input  wire logic [PORTS-1:0] rule_map,
  input  wire logic [PORTS-1:0] lut_map,
  // Result
  output logic      [PORTS-1:0] out_map
);

  // Bit n of each map is port n+1
  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_port
      always_comb begin
        case (map_combine_mode)
          `AFM_MM_LUT_ONLY:  out_map[g] = lut_map[g];
          `AFM_MM_OR:        out_map[g] = rule_map[g] | lut_map[g];
          `AFM_MM_AND:       out_map[g] = rule_map[g] & lut_map[g];
          `AFM_MM_RULE_ONLY: out_map[g] = rule_map[g];
          default:           out_map[g] = lut_map[g];
        endcase
      end
    end
  endgenerate

endmodule : afm_map_combine

// ---- verilog/afm_tick_gen.sv ----
// Microsecond or millisecond tick for the countdown
`timescale 1ns/100ps
`include "afm_params.svh"

module afm_tick_gen
  import afm_pkg::*;
#(
  parameter int US_CYCLES = `AFM_US_CYCLES,
  parameter int MS_US     = `AFM_MS_US
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic run,
  input  wire logic unit_ms,
  // Pulse, one cycle per unit
  output logic      tick
);

  afm_tick_state_type s;
  afm_tick_state_type next_s;

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    // Restarting on every stop keeps the first unit whole
    if (!run) begin
      next_s.sub = '0;
      next_s.msc = '0;
    end else if (s.sub == `AFM_SUB_W'(US_CYCLES - 1)) begin
      next_s.sub = '0;
      if (!unit_ms) begin
        next_s.tick = 1'b1;
      end else if (s.msc == `AFM_MS_W'(MS_US - 1)) begin
        next_s.msc  = '0;
        next_s.tick = 1'b1;
      end else begin
        next_s.msc = s.msc + `AFM_MS_W'(1);
      end
    end else begin
      next_s.sub = s.sub + `AFM_SUB_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule : afm_tick_gen

// ---- verilog/afm_top.sv ----
// Rule action stage: AHB-Lite registers, forwarding map combine, rule counter, interrupt
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "afm_params.svh"

module afm_top
  import afm_pkg::*;
#(
  parameter int PORTS     = `AFM_PORTS,
  parameter int US_CYCLES = `AFM_US_CYCLES,
  parameter int MS_US     = `AFM_MS_US
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // Matched packet from the rule matcher
  input  wire logic             pkt_match,
  input  wire logic [PORTS-1:0] lut_map,
  // Forwarding and priority decision
  output logic                  fwd_valid,
  output logic [PORTS-1:0]      fwd_map,
  output logic                  remark_prio_enable,
  output logic [2:0]            remark_prio_value,
  output logic [1:0]            prio_select_mode,
  output logic [2:0]            prio_value,
  // Interrupt
  output logic                  irq
);

  afm_state_type          s;
  afm_state_type          next_s;
  logic [PORTS-1:0]       comb_map;
  logic                   tick;
  logic                   addr_take;
  logic [2:0]             addr_idx;
  logic                   count_mode;
  logic                   count_up;
  logic [`AFM_CNT_W-1:0]  target;
  logic                   expire;
  logic                   status_rd;
  logic [7:0]             wbyte;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic [2:0] reg_index(input logic [31:0] a);
    logic [2:0] idx;
    idx = `AFM_IDX_NONE;
    case (a[7:0])
      `AFM_ADDR_CONFIG:     idx = `AFM_IDX_CONFIG;
      `AFM_ADDR_ACTION_HI:  idx = `AFM_IDX_ACTION_HI;
      `AFM_ADDR_FWD_ACTION: idx = `AFM_IDX_FWD_ACTION;
      `AFM_ADDR_STATUS:     idx = `AFM_IDX_STATUS;
      `AFM_ADDR_MASK:       idx = `AFM_IDX_MASK;
      `AFM_ADDR_COUNT:      idx = `AFM_IDX_COUNT;
      default:              idx = `AFM_IDX_NONE;
    endcase
    // Upper address bits must be zero to hit a register
    if (a[31:8] != 24'h00_0000) begin
      idx = `AFM_IDX_NONE;
    end
    return idx;
  endfunction : reg_index

  // Read mux over the values the registers take at this edge, so a read right after a write sees it
  function automatic logic [31:0] read_word(input logic [2:0] idx, input afm_state_type v, input logic st);
    logic [31:0] w;
    w = `AFM_RST_WORD;
    case (idx)
      `AFM_IDX_CONFIG: begin
        w[`AFM_CFG_KIND_HI:`AFM_CFG_KIND_LO] = v.rule_kind_select;
        w[`AFM_CFG_EN_HI:`AFM_CFG_EN_LO]     = v.rule_action_enable;
      end
      `AFM_IDX_ACTION_HI: begin
        w[7:0] = v.act_hi;
      end
      `AFM_IDX_FWD_ACTION: begin
        w[7:0] = v.act_fwd;
      end
      `AFM_IDX_STATUS: begin
        w[0] = st;
      end
      `AFM_IDX_MASK: begin
        w[0] = v.mask;
      end
      `AFM_IDX_COUNT: begin
        w[`AFM_CNT_W-1:0] = v.cnt;
      end
      default: begin
        w = `AFM_RST_WORD;
      end
    endcase
    return w;
  endfunction : read_word

  assign addr_take = hsel & htrans[1] & hready;
  assign addr_idx  = reg_index(haddr);
  assign wbyte     = hwdata[7:0];
  assign status_rd = addr_take & ~hwrite & (addr_idx == `AFM_IDX_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers on current state

  // Counter mode borrows the unit and direction bits of the port map
  assign count_mode = (s.rule_kind_select == `AFM_KIND_COUNT) &&
                      (s.rule_action_enable == `AFM_EN_COUNT);
  assign count_up   = s.act_fwd[`AFM_FWD_DIR_BIT];
  // The 11-bit count target is the whole upper action byte over bits 7:5 of the forward action byte
  assign target     = {s.act_hi, s.act_fwd[`AFM_FWD_RP_LSB:`AFM_FWD_MM_LO]};

  afm_map_combine #(
    .PORTS            (PORTS)
  ) u_combine (
    .map_combine_mode (s.act_fwd[`AFM_FWD_MM_HI:`AFM_FWD_MM_LO]),
    .rule_map         (s.act_fwd[PORTS-1:0]),
    .lut_map          (lut_map),
    .out_map          (comb_map)
  );

  afm_tick_gen #(
    .US_CYCLES (US_CYCLES),
    .MS_US     (MS_US)
  ) u_tick (
    .clk       (clk),
    .rst       (rst),
    .run       (count_mode && !count_up && (s.cst == AFM_CNT_RUN) && !s.reload),
    .unit_ms   (s.act_fwd[`AFM_FWD_UNIT_BIT]),
    .tick      (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s           = s;
    expire           = 1'b0;
    next_s.hreadyout = 1'b1;
    next_s.hresp     = 1'b0;
    next_s.reload    = 1'b0;

    // Data phase of a write: zero wait states, data taken now
    if (s.dph_wr) begin
      case (s.dph_idx)
        `AFM_IDX_CONFIG: begin
          next_s.rule_kind_select   = wbyte[`AFM_CFG_KIND_HI:`AFM_CFG_KIND_LO];
          next_s.rule_action_enable = wbyte[`AFM_CFG_EN_HI:`AFM_CFG_EN_LO];
          next_s.reload             = 1'b1;
        end
        `AFM_IDX_ACTION_HI: begin
          next_s.act_hi = wbyte;
          next_s.reload = 1'b1;
        end
        `AFM_IDX_FWD_ACTION: begin
          next_s.act_fwd = wbyte;
          next_s.reload  = 1'b1;
        end
        `AFM_IDX_MASK: begin
          next_s.mask = wbyte[0];
        end
        `AFM_IDX_STATUS: begin
          // Status clears only by being read, so a write here is dropped
        end
        `AFM_IDX_COUNT: begin
          // Counter is read only; software restarts it through the action bytes
        end
        default: begin
        end
      endcase
    end

    // Rule counter
    if (!count_mode) begin
      next_s.cst = AFM_CNT_IDLE;
      next_s.cnt = `AFM_RST_CNT;
    end else if (s.reload || (s.cst == AFM_CNT_IDLE)) begin
      // Any change of the action fields restarts the count
      next_s.cst = AFM_CNT_RUN;
      next_s.cnt = count_up ? `AFM_RST_CNT : target;
    end else if (s.cst == AFM_CNT_RUN) begin
      if (!count_up) begin
        // A zero target expires on the first cycle after the load
        if (s.cnt == `AFM_RST_CNT) begin
          expire     = 1'b1;
          next_s.cst = AFM_CNT_DONE;
        end else if (tick) begin
          next_s.cnt = s.cnt - `AFM_CNT_W'(1);
        end
      end else begin
        if (s.cnt == target) begin
          expire     = 1'b1;
          next_s.cst = AFM_CNT_DONE;
        end else if (pkt_match) begin
          next_s.cnt = s.cnt + `AFM_CNT_W'(1);
        end
      end
    end

    // Forwarding and remark decision for each matched packet
    next_s.fwd_valid = pkt_match;
    if (pkt_match) begin
      if (count_mode) begin
        // Port map bits are counter controls here, so the table decides alone
        next_s.fwd_map     = lut_map;
        next_s.remark_en   = 1'b0;
        next_s.remark_prio = 3'h0;
        next_s.prio_mode   = 2'h0;
        next_s.prio_value  = 3'h0;
      end else begin
        next_s.fwd_map     = comb_map;
        next_s.remark_en   = s.act_hi[`AFM_HI_RPE_BIT];
        if (s.act_hi[`AFM_HI_RPE_BIT]) begin
          next_s.remark_prio = {s.act_hi[`AFM_HI_RP_HI:`AFM_HI_RP_LO], s.act_fwd[`AFM_FWD_RP_LSB]};
        end else begin
          next_s.remark_prio = 3'h0;
        end
        next_s.prio_mode   = s.act_hi[`AFM_HI_PM_HI:`AFM_HI_PM_LO];
        next_s.prio_value  = s.act_hi[`AFM_HI_P_HI:`AFM_HI_P_LO];
      end
    end

    // Address phase: latch the target, answer reads from the updated values
    next_s.dph_wr  = 1'b0;
    next_s.dph_idx = `AFM_IDX_NONE;
    next_s.hrdata  = `AFM_RST_WORD;
    if (addr_take) begin
      next_s.dph_wr  = hwrite;
      next_s.dph_idx = addr_idx;
      if (!hwrite) begin
        next_s.hrdata = read_word(addr_idx, next_s, s.status | expire);
      end
    end

    // Sticky status: a read clears it, an expiry in the same cycle survives
    if (status_rd) begin
      next_s.status = expire;
    end else begin
      next_s.status = s.status | expire;
    end
    next_s.irq = next_s.status & next_s.mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s                    <= '0;
      s.hreadyout          <= 1'b1;
      s.dph_idx            <= `AFM_IDX_NONE;
      s.rule_kind_select   <= `AFM_RST_CFG;
      s.rule_action_enable <= `AFM_RST_CFG;
      s.act_hi             <= `AFM_RST_BYTE;
      s.act_fwd            <= `AFM_RST_BYTE;
      s.cnt                <= `AFM_RST_CNT;
      s.cst                <= AFM_CNT_IDLE;
      s.fwd_map            <= `AFM_RST_PORTS;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout          = s.hreadyout;
  assign hresp              = s.hresp;
  assign hrdata             = s.hrdata;
  assign fwd_valid          = s.fwd_valid;
  assign fwd_map            = s.fwd_map;
  assign remark_prio_enable = s.remark_en;
  assign remark_prio_value  = s.remark_prio;
  assign prio_select_mode   = s.prio_mode;
  assign prio_value         = s.prio_value;
  assign irq                = s.irq;

endmodule : afm_top
